// ### mx2_pkg.sv
// constants and state type for the second routing matrix output select
// assumes a single synchronous clock domain and an external config image source
package mx2_pkg;

  // ==========================================================================
  // configuration image layout
  localparam int SEL_W = 6;
  localparam int NUM_OUT = 95;
  localparam int NUM_IN = 64;
  localparam int NUM_FIELDS = 96;
  localparam int CFG_BASE_BIT = 1024;
  localparam int CFG_TOP_BIT = 1599;
  localparam int IMAGE_W = NUM_FIELDS * SEL_W;
  localparam int ROUTE_W = NUM_OUT * SEL_W;

  // ==========================================================================
  // input numbering
  localparam int IN_LOCAL_COUNT = 52;
  localparam int IN_CROSS_BASE = 52;
  localparam int CROSS_COUNT = 10;
  localparam int IN_RESET_CODE = 62;
  localparam logic [SEL_W-1:0] CODE_SUPPLY_HIGH = 6'h3f;
  localparam logic [SEL_W-1:0] SEL_RESET = 6'h00;

  // ==========================================================================
  // output numbering
  localparam int OUT_LUT_BASE = 0;
  localparam int LUT_COUNT = 36;
  localparam int OUT_LATCH_BASE = 36;
  localparam int LATCH_COUNT = 15;
  localparam int OUT_PIPE_CLOCK = 51;
  localparam int OUT_PIPE_DATA = 52;
  localparam int OUT_PIPE_RESET = 53;
  localparam int OUT_EDGE_IN = 54;
  localparam int OUT_INVERTER_IN = 55;
  localparam int OUT_PIN12 = 56;
  localparam int OUT_PIN13 = 57;
  localparam int OUT_PIN14 = 59;
  localparam int OUT_PIN15 = 61;
  localparam int OUT_PIN16 = 62;
  localparam int OUT_PIN17 = 64;
  localparam int OUT_PIN18 = 65;
  localparam int OUT_PIN19 = 67;
  localparam int OUT_PIN20 = 69;
  localparam int OUT_CMP_PD_BASE = 70;
  localparam int OUT_CLOCK_TWO = 73;
  localparam int OUT_CLOCK_THREE = 74;
  localparam int OUT_CNT_ONE = 75;
  localparam int OUT_CNT_THREE = 76;
  localparam int OUT_CNT_FOUR = 77;
  localparam int OUT_CNT_FOUR_HOLD = 78;
  localparam int OUT_CNT_FOUR_UP = 79;
  localparam int OUT_CNT_SEVEN = 80;
  localparam int OUT_CNT_EIGHT = 81;
  localparam int OUT_PWM_PD = 82;
  localparam int OUT_OPSEL_B0 = 83;
  localparam int OUT_OPSEL_B1 = 84;
  localparam int OUT_CROSS_BASE = 85;

  // ==========================================================================
  // state
  typedef struct packed {
    logic [ROUTE_W-1:0] sel;
    logic loaded;
  } mx2_state_t;

  // selector field of one output within a flat selector vector
  function automatic logic [SEL_W-1:0] mx2_field(input logic [ROUTE_W-1:0] flat,
                                                 input int idx);
    mx2_field = flat[idx*SEL_W +: SEL_W];
  endfunction

endpackage

// ### mx2_sel_mux.sv
// bank of 64-to-1 selectors, one per matrix output
// assumes selector fields are packed six bits per output, output 0 lowest
`timescale 1ns/1ps
module mx2_sel_mux #(
  parameter int N_OUT = 95,
  parameter int SEL_W = 6,
  parameter int N_IN = 64
) (
  // selectors and sources
  input wire logic [N_OUT*SEL_W-1:0] i_sel_flat,
  input wire logic [N_IN-1:0] i_in,
  // routed signals
  output logic [N_OUT-1:0] o_out
);

  // ==========================================================================
  // pure combinational selection, no stage in the signal path
  always_comb begin
    o_out = '0;
    for (int k = 0; k < N_OUT; k++) begin
      o_out[k] = i_in[i_sel_flat[k*SEL_W +: SEL_W]];
    end
  end

endmodule

// ### mx2_output_select.sv
// second routing matrix: selector storage and routed macrocell inputs
// assumes the configuration image is presented once after reset with a load pulse
`timescale 1ns/1ps

// Functional notes
// - six-bit field per output, from bit 1024
// - code N picks input N, 63 high
// - outputs 0..35 feed lookup table inputs
// - outputs 36..50 feed latch cell controls
// - outputs 51..53 drive pipe delay
// - 54 edge detector, 55 inverter input
// - pins 12,15,17,20 data only
// - pins 13,14,16,18,19 data plus enable
// - outputs 70..72 comparator power-down, active low
// - output 73 shared routed clock two
// - output 74 shared routed clock three
// - counter inputs 75,76,77,80,81
// - 78 hold, 79 count-up of counter four
// - output 82 pwm power-down
// - 83,84 operand select code bits
// - 85..94 cross signals to first matrix
module mx2_output_select (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // configuration image, bits 1599 down to 1024
  input wire logic [mx2_pkg::IMAGE_W-1:0] i_cfg_image,
  input wire logic i_cfg_load,
  // matrix sources
  input wire logic [mx2_pkg::IN_LOCAL_COUNT-1:0] i_sources,
  input wire logic [mx2_pkg::CROSS_COUNT-1:0] i_cross_from_first,
  input wire logic i_routed_reset_active_low,
  // status
  output logic o_cfg_loaded,
  // logic cell inputs
  output logic [mx2_pkg::LUT_COUNT-1:0] o_lut_inputs,
  output logic [mx2_pkg::LATCH_COUNT-1:0] o_latch_ctl,
  output logic o_pipe_clock,
  output logic o_pipe_data,
  output logic o_pipe_reset,
  output logic o_edge_in,
  output logic o_inverter_in,
  // pins: data-only 12,15,17,20; data+enable 13,14,16,18,19
  output logic [3:0] o_pin_data_only,
  output logic [4:0] o_pin_data,
  output logic [4:0] o_pin_oe,
  // analog and counter controls
  output logic [2:0] o_cmp_power_down_active_low,
  output logic o_routed_clock_two,
  output logic o_routed_clock_three,
  output logic [4:0] o_counter_in,
  output logic o_counter_four_hold,
  output logic o_counter_four_up,
  output logic o_pwm_power_down,
  output logic [1:0] o_operand_sel,
  // cross signals to the first matrix
  output logic [mx2_pkg::CROSS_COUNT-1:0] o_cross_to_first
);

  // ==========================================================================
  // state
  mx2_pkg::mx2_state_t state_reg;
  mx2_pkg::mx2_state_t state_next;
  logic [mx2_pkg::NUM_IN-1:0] in_vec;
  logic [mx2_pkg::NUM_OUT-1:0] route;

  // selectors load once and then lock until i_srst clears them back to code 0 and reopens the load
  always_comb begin
    state_next = state_reg;
    if (i_cfg_load && !state_reg.loaded) begin
      state_next.sel = i_cfg_image[mx2_pkg::ROUTE_W-1:0];
      state_next.loaded = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg.sel <= {mx2_pkg::NUM_OUT{mx2_pkg::SEL_RESET}};
      state_reg.loaded <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_cfg_loaded = state_reg.loaded;

  // ==========================================================================
  // source vector: code 63 is tied high, 52..61 come from the first matrix
  assign in_vec = {1'b1, i_routed_reset_active_low, i_cross_from_first, i_sources};

  // the routed path stays combinational on purpose: a register here would add
  // a cycle of skew between cells that the configuration expects to be wired
  mx2_sel_mux #(
    .N_OUT(mx2_pkg::NUM_OUT),
    .SEL_W(mx2_pkg::SEL_W),
    .N_IN(mx2_pkg::NUM_IN)
  ) i_mx2_sel_mux (
    .i_sel_flat(state_reg.sel),
    .i_in(in_vec),
    .o_out(route)
  );

  // ==========================================================================
  // output fan-out
  assign o_lut_inputs = route[mx2_pkg::OUT_LUT_BASE +: mx2_pkg::LUT_COUNT];
  assign o_latch_ctl = route[mx2_pkg::OUT_LATCH_BASE +: mx2_pkg::LATCH_COUNT];
  assign o_pipe_clock = route[mx2_pkg::OUT_PIPE_CLOCK];
  assign o_pipe_data = route[mx2_pkg::OUT_PIPE_DATA];
  assign o_pipe_reset = route[mx2_pkg::OUT_PIPE_RESET];
  assign o_edge_in = route[mx2_pkg::OUT_EDGE_IN];
  assign o_inverter_in = route[mx2_pkg::OUT_INVERTER_IN];
  assign o_pin_data_only = {route[mx2_pkg::OUT_PIN20], route[mx2_pkg::OUT_PIN17],
                            route[mx2_pkg::OUT_PIN15], route[mx2_pkg::OUT_PIN12]};
  assign o_pin_data = {route[mx2_pkg::OUT_PIN19], route[mx2_pkg::OUT_PIN18],
                       route[mx2_pkg::OUT_PIN16], route[mx2_pkg::OUT_PIN14],
                       route[mx2_pkg::OUT_PIN13]};
  assign o_pin_oe = {route[mx2_pkg::OUT_PIN19 + 1], route[mx2_pkg::OUT_PIN18 + 1],
                     route[mx2_pkg::OUT_PIN16 + 1], route[mx2_pkg::OUT_PIN14 + 1],
                     route[mx2_pkg::OUT_PIN13 + 1]};
  assign o_cmp_power_down_active_low = route[mx2_pkg::OUT_CMP_PD_BASE +: 3];
  assign o_routed_clock_two = route[mx2_pkg::OUT_CLOCK_TWO];
  assign o_routed_clock_three = route[mx2_pkg::OUT_CLOCK_THREE];
  assign o_counter_in = {route[mx2_pkg::OUT_CNT_EIGHT], route[mx2_pkg::OUT_CNT_SEVEN],
                         route[mx2_pkg::OUT_CNT_FOUR], route[mx2_pkg::OUT_CNT_THREE],
                         route[mx2_pkg::OUT_CNT_ONE]};
  assign o_counter_four_hold = route[mx2_pkg::OUT_CNT_FOUR_HOLD];
  assign o_counter_four_up = route[mx2_pkg::OUT_CNT_FOUR_UP];
  assign o_pwm_power_down = route[mx2_pkg::OUT_PWM_PD];
  assign o_operand_sel = {route[mx2_pkg::OUT_OPSEL_B1], route[mx2_pkg::OUT_OPSEL_B0]};
  assign o_cross_to_first = route[mx2_pkg::OUT_CROSS_BASE +: mx2_pkg::CROSS_COUNT];

  // ==========================================================================
  // checks
  a_field_zero: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_cfg_load && !state_reg.loaded) |=>
      mx2_pkg::mx2_field(state_reg.sel, 0) == $past(i_cfg_image[5:0]))
    else $error("output 0 selector not taken from the lowest field");

  a_last_field: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_cfg_load && !state_reg.loaded) |=>
      mx2_pkg::mx2_field(state_reg.sel, 94) == $past(i_cfg_image[569:564]))
    else $error("last selector field misplaced");

  a_supply_high: assert property (@(posedge i_clk) disable iff (i_srst)
    (mx2_pkg::mx2_field(state_reg.sel, 36) == mx2_pkg::CODE_SUPPLY_HIGH) |-> o_latch_ctl[0])
    else $error("code 63 did not give a high level");

  a_cross_in: assert property (@(posedge i_clk) disable iff (i_srst)
    (mx2_pkg::mx2_field(state_reg.sel, 7) == 6'h34) |->
      (o_lut_inputs[7] == i_cross_from_first[0]))
    else $error("code 52 did not pick cross input 0");

  a_lut_last: assert property (@(posedge i_clk) disable iff (i_srst)
    o_lut_inputs[35] == in_vec[mx2_pkg::mx2_field(state_reg.sel, 35)])
    else $error("output 35 misrouted");

  a_pin13_pair: assert property (@(posedge i_clk) disable iff (i_srst)
    (o_pin_data[0] == in_vec[mx2_pkg::mx2_field(state_reg.sel, 57)]) &&
    (o_pin_oe[0] == in_vec[mx2_pkg::mx2_field(state_reg.sel, 58)]))
    else $error("pin 13 value or enable misrouted");

  a_pin12_only: assert property (@(posedge i_clk) disable iff (i_srst)
    o_pin_data_only[0] == in_vec[mx2_pkg::mx2_field(state_reg.sel, 56)])
    else $error("pin 12 misrouted");

  a_clock_two: assert property (@(posedge i_clk) disable iff (i_srst)
    o_routed_clock_two == in_vec[mx2_pkg::mx2_field(state_reg.sel, 73)])
    else $error("routed clock two misrouted");

  a_cnt_four_up: assert property (@(posedge i_clk) disable iff (i_srst)
    o_counter_four_up == in_vec[mx2_pkg::mx2_field(state_reg.sel, 79)])
    else $error("counter four up control misrouted");

  a_opsel_order: assert property (@(posedge i_clk) disable iff (i_srst)
    o_operand_sel[1] == in_vec[mx2_pkg::mx2_field(state_reg.sel, 84)])
    else $error("operand select bit 1 misrouted");

  a_sel_locked: assert property (@(posedge i_clk) disable iff (i_srst)
    state_reg.loaded |=> ($stable(state_reg.sel) && state_reg.loaded))
    else $error("selectors changed after load");

  a_latch_last: assert property (@(posedge i_clk) disable iff (i_srst)
    o_latch_ctl[14] == in_vec[mx2_pkg::mx2_field(state_reg.sel, 50)])
    else $error("output 50 misrouted");

  a_pipe_reset: assert property (@(posedge i_clk) disable iff (i_srst)
    o_pipe_reset == in_vec[mx2_pkg::mx2_field(state_reg.sel, 53)])
    else $error("pipe delay reset misrouted");

  a_edge_inverter: assert property (@(posedge i_clk) disable iff (i_srst)
    (o_edge_in == in_vec[mx2_pkg::mx2_field(state_reg.sel, 54)]) &&
    (o_inverter_in == in_vec[mx2_pkg::mx2_field(state_reg.sel, 55)]))
    else $error("edge detector or inverter input misrouted");

  a_cmp_power_down: assert property (@(posedge i_clk) disable iff (i_srst)
    o_cmp_power_down_active_low[2] == in_vec[mx2_pkg::mx2_field(state_reg.sel, 72)])
    else $error("comparator three power-down misrouted");

  a_clock_three: assert property (@(posedge i_clk) disable iff (i_srst)
    o_routed_clock_three == in_vec[mx2_pkg::mx2_field(state_reg.sel, 74)])
    else $error("routed clock three misrouted");

  a_cnt_seven_in: assert property (@(posedge i_clk) disable iff (i_srst)
    o_counter_in[3] == in_vec[mx2_pkg::mx2_field(state_reg.sel, 80)])
    else $error("counter seven input misrouted");

  a_pwm_power_down: assert property (@(posedge i_clk) disable iff (i_srst)
    o_pwm_power_down == in_vec[mx2_pkg::mx2_field(state_reg.sel, 82)])
    else $error("pwm power-down misrouted");

  a_cross_last: assert property (@(posedge i_clk) disable iff (i_srst)
    o_cross_to_first[9] == in_vec[mx2_pkg::mx2_field(state_reg.sel, 94)])
    else $error("cross signal 9 misrouted");

endmodule

// ### mx2_output_select_test.sv
// self-checking testbench for the second routing matrix output select
// assumes routed outputs are combinational and selectors load once per reset
`timescale 1ns/1ps
module mx2_output_select_test;
  // ==========================================================================
  // stimulus and observed signals
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [mx2_pkg::IMAGE_W-1:0] i_cfg_image = '0;
  logic i_cfg_load = 1'b0;
  logic [mx2_pkg::IN_LOCAL_COUNT-1:0] i_sources = '0;
  logic [mx2_pkg::CROSS_COUNT-1:0] i_cross_from_first = '0;
  logic i_routed_reset_active_low = 1'b0;
  logic o_cfg_loaded, o_pipe_clock, o_pipe_data, o_pipe_reset, o_edge_in, o_inverter_in;
  logic o_routed_clock_two, o_routed_clock_three, o_counter_four_hold, o_counter_four_up;
  logic o_pwm_power_down;
  logic [mx2_pkg::LUT_COUNT-1:0] o_lut_inputs;
  logic [mx2_pkg::LATCH_COUNT-1:0] o_latch_ctl;
  logic [3:0] o_pin_data_only;
  logic [4:0] o_pin_data, o_pin_oe, o_counter_in;
  logic [2:0] o_cmp_power_down_active_low;
  logic [1:0] o_operand_sel;
  logic [mx2_pkg::CROSS_COUNT-1:0] o_cross_to_first;
  logic [94:0] got;
  logic [mx2_pkg::IMAGE_W-1:0] img_a, img_b;
  // source patterns: bit 62 reset input, 61..52 cross inputs, 51..0 local
  logic [63:0] rows [6] = '{64'h0000_0000_0000_0000, 64'hffff_ffff_ffff_ffff,
    64'h5555_5555_5555_5555, 64'haaaa_aaaa_aaaa_aaaa, 64'h0123_4567_89ab_cdef,
    64'hfedc_ba98_7654_3210};
  int bad_count = 0;
  int samples_checked = 0;

  always #50 i_clk = ~i_clk;

  mx2_output_select i_mx2_output_select (.i_clk(i_clk), .i_srst(i_srst),
    .i_cfg_image(i_cfg_image), .i_cfg_load(i_cfg_load), .i_sources(i_sources),
    .i_cross_from_first(i_cross_from_first),
    .i_routed_reset_active_low(i_routed_reset_active_low), .o_cfg_loaded(o_cfg_loaded),
    .o_lut_inputs(o_lut_inputs), .o_latch_ctl(o_latch_ctl), .o_pipe_clock(o_pipe_clock),
    .o_pipe_data(o_pipe_data), .o_pipe_reset(o_pipe_reset), .o_edge_in(o_edge_in),
    .o_inverter_in(o_inverter_in), .o_pin_data_only(o_pin_data_only),
    .o_pin_data(o_pin_data), .o_pin_oe(o_pin_oe),
    .o_cmp_power_down_active_low(o_cmp_power_down_active_low),
    .o_routed_clock_two(o_routed_clock_two), .o_routed_clock_three(o_routed_clock_three),
    .o_counter_in(o_counter_in), .o_counter_four_hold(o_counter_four_hold),
    .o_counter_four_up(o_counter_four_up), .o_pwm_power_down(o_pwm_power_down),
    .o_operand_sel(o_operand_sel), .o_cross_to_first(o_cross_to_first));

  // routed outputs gathered back into matrix output order
  assign got = {o_cross_to_first, o_operand_sel, o_pwm_power_down, o_counter_in[4:3],
    o_counter_four_up, o_counter_four_hold, o_counter_in[2:0], o_routed_clock_three,
    o_routed_clock_two, o_cmp_power_down_active_low, o_pin_data_only[3], o_pin_oe[4],
    o_pin_data[4], o_pin_oe[3], o_pin_data[3], o_pin_data_only[2], o_pin_oe[2],
    o_pin_data[2], o_pin_data_only[1], o_pin_oe[1], o_pin_data[1], o_pin_oe[0],
    o_pin_data[0], o_pin_data_only[0], o_inverter_in, o_edge_in, o_pipe_reset,
    o_pipe_data, o_pipe_clock, o_latch_ctl, o_lut_inputs};

  // ==========================================================================
  // helpers
  // coprime step makes the first 64 outputs use every code once
  function automatic logic [mx2_pkg::IMAGE_W-1:0] make_img(input int mul, input int add,
                                                           input logic [5:0] rsv);
    logic [mx2_pkg::IMAGE_W-1:0] img;
    img = '0;
    for (int n = 0; n < mx2_pkg::NUM_OUT; n++) begin
      img[n*mx2_pkg::SEL_W +: mx2_pkg::SEL_W] = 6'((n * mul + add) % 64);
    end
    img[mx2_pkg::ROUTE_W +: mx2_pkg::SEL_W] = rsv;
    return img;
  endfunction

  function automatic logic [94:0] exp_route(input logic [mx2_pkg::IMAGE_W-1:0] img,
                                            input logic [63:0] src);
    logic [94:0] r;
    for (int n = 0; n < mx2_pkg::NUM_OUT; n++) begin
      r[n] = src[img[n*mx2_pkg::SEL_W +: mx2_pkg::SEL_W]];
    end
    return r;
  endfunction

  task automatic check(input string name, input logic [94:0] exp, input logic [94:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apply(input logic [63:0] p);
    @(posedge i_clk);
    #2;
    i_sources = p[51:0];
    i_cross_from_first = p[61:52];
    i_routed_reset_active_low = p[62];
    @(negedge i_clk);
  endtask

  // checked in the same cycle the sources change, so no register stage can hide
  task automatic check_route(input logic [mx2_pkg::IMAGE_W-1:0] img, input logic [63:0] p);
    logic [94:0] e;
    e = exp_route(img, {1'b1, p[62:0]});
    check("lut_inputs", 95'(e[35:0]), 95'(got[35:0]));
    check("latch_ctl", 95'(e[50:36]), 95'(got[50:36]));
    check("pipe_edge_inv", 95'(e[55:51]), 95'(got[55:51]));
    check("pins", 95'(e[69:56]), 95'(got[69:56]));
    check("analog_clocks", 95'(e[74:70]), 95'(got[74:70]));
    check("counters_pwm", 95'(e[82:75]), 95'(got[82:75]));
    check("opsel_cross", 95'(e[94:83]), 95'(got[94:83]));
  endtask

  task automatic pulse_load(input logic [mx2_pkg::IMAGE_W-1:0] img);
    @(posedge i_clk);
    #2;
    i_cfg_image = img;
    i_cfg_load = 1'b1;
    @(posedge i_clk);
    #2;
    i_cfg_load = 1'b0;
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================================
  // sequence
  initial begin
    img_a = make_img(7, 3, 6'h2a);
    img_b = make_img(5, 1, 6'h15);
    repeat (8) @(posedge i_clk);
    #2;
    i_srst = 1'b0;
    check("cfg_loaded", 95'(0), 95'(o_cfg_loaded));
    apply(rows[4]);
    check_route('0, rows[4]);
    pulse_load(img_a);
    check("cfg_loaded", 95'(1), 95'(o_cfg_loaded));
    for (int i = 0; i < 6; i++) begin
      apply(rows[i]);
      check_route(img_a, rows[i]);
    end
    $display("test first_load done");
    // a second load must leave the routing alone
    pulse_load(img_b);
    apply(rows[5]);
    check_route(img_a, rows[5]);
    $display("test second_load_ignored done");
    // reset in mid-run clears the selectors, then a new image is accepted
    @(posedge i_clk);
    #2;
    i_srst = 1'b1;
    @(posedge i_clk);
    #2;
    i_srst = 1'b0;
    check("cfg_loaded", 95'(0), 95'(o_cfg_loaded));
    apply(rows[5]);
    check_route('0, rows[5]);
    pulse_load(img_b);
    check("cfg_loaded", 95'(1), 95'(o_cfg_loaded));
    for (int i = 0; i < 6; i++) begin
      apply(rows[i]);
      check_route(img_b, rows[i]);
    end
    $display("test reload_after_reset done");
    end_sim();
  end
endmodule
